//--- design/lmef_pkg.sv
// Package for the list-mode event framer: word layout, modes, timing.
// Assumes a single 50 MHz system clock shared by all users.
package lmef_pkg;
    localparam int          LMEF_NCH          = 4;
    localparam int          LMEF_TS_W         = 44;
    localparam int          LMEF_FIFO_DEPTH   = 32;
    localparam int          LMEF_WORD_W       = 64;
    // Word field positions
    localparam int          LMEF_CH_LSB       = 0;
    localparam int          LMEF_PILE_BIT     = 2;
    localparam int          LMEF_WAVE_BIT     = 3;
    localparam int          LMEF_TS_LSB       = 4;
    localparam int          LMEF_VAL_LSB      = 48;
    localparam int          LMEF_TAG_W        = 8;
    localparam int          LMEF_PW_W         = 12;
    // Mode field positions
    localparam int          LMEF_MODE_PHA_LSB = 0;
    localparam int          LMEF_MODE_PUR_LSB = 4;
    // Trailer length field, 12 samples (three counter words) minus one
    localparam logic [15:0] LMEF_TRAILER_LEN  = 16'h000b;
    localparam logic [1:0]  LMEF_NCNT         = 2'h2;
    // Allowed waveform lengths minus one
    localparam logic [15:0] LMEF_WLEN_4K      = 16'h0fff;
    localparam logic [15:0] LMEF_WLEN_8K      = 16'h1fff;
    localparam logic [15:0] LMEF_WLEN_16K     = 16'h3fff;
    localparam logic [15:0] LMEF_WLEN_32K     = 16'h7fff;
    // Timestamp units
    localparam int          LMEF_CLK_NS       = 20;
    localparam int          LMEF_FINE_NS      = 8;
    localparam int          LMEF_COARSE_NS    = 1000000;
    localparam int          LMEF_PW_UNIT_NS   = 64;
    localparam int          LMEF_COARSE_CYC   = LMEF_COARSE_NS / LMEF_CLK_NS;
    localparam int          LMEF_FINE_STEP    = LMEF_CLK_NS / LMEF_FINE_NS;
    typedef enum logic [5:0] {
        LMEF_IDLE    = 6'h01,
        LMEF_HEAD    = 6'h02,
        LMEF_WAVE    = 6'h04,
        LMEF_TRL_HD  = 6'h08,
        LMEF_TRL_CNT = 6'h10,
        LMEF_DONE    = 6'h20
    } lmef_state_t;
endpackage

//--- design/lmef_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; depth is a power of two.
`timescale 1ns/100ps
`default_nettype none
module lmef_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             nrst,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wptr;
    logic [AW:0]      rptr;
    logic             push;
    logic             pop;
    assign in_ready  = (wptr - rptr) != (AW+1)'(DEPTH);
    assign out_valid = wptr != rptr;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rptr[AW-1:0]];
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wptr[AW-1:0]] <= in_data;
        end
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wptr <= '0;
            rptr <= '0;
        end else begin
            if (push) begin
                wptr <= wptr + 1'b1;
            end
            if (pop) begin
                rptr <= rptr + 1'b1;
            end
        end
    end
endmodule // lmef_fifo
`default_nettype wire

//--- design/lmef_framer.sv
// Top of the list-mode event framer: frames events into 64-bit words,
// buffers them and serialises bytes least significant first.
// Assumes events and samples come from logic on sys_clk; dig inputs are pins.
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
`default_nettype none
module lmef_framer (
    // Clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   nrst,
    // Configuration
    input  wire logic [3:0]             channel_enable_mask,
    input  wire logic [7:0]             sample_mode,
    input  wire logic                   fine_time_en,
    input  wire logic                   tag_en,
    input  wire logic                   pulse_width_en,
    input  wire logic [1:0]             wave_len_sel,
    input  wire logic                   acq_stop,
    // Pins
    input  wire logic [7:0]             dig_in,
    // Event from acquisition
    input  wire logic                   ev_valid,
    output logic                        ev_ready,
    input  wire logic [1:0]             ev_channel,
    input  wire logic                   ev_pileup,
    input  wire logic [15:0]            ev_adc,
    input  wire logic [11:0]            ev_pulse_width,
    // Waveform samples
    input  wire logic                   smp_valid,
    output logic                        smp_ready,
    input  wire logic [15:0]            smp_data,
    // Counters per channel, flattened 4 x 64
    input  wire logic [255:0]           real_time,
    input  wire logic [255:0]           live_time,
    input  wire logic [255:0]           event_count,
    // Byte stream out
    output logic                        byte_valid,
    input  wire logic                   byte_ready,
    output logic [7:0]                  byte_data,
    // Status
    output logic                        trailer_done,
    output logic [43:0]                 timestamp
);
    import lmef_pkg::*;

    logic [7:0]        dig_meta;
    logic [7:0]        dig_sync;
    logic [25:0]       coarse_div;
    lmef_state_t       state;
    logic [63:0]       frame_word;
    logic              frame_valid;
    logic              frame_ready;
    logic [63:0]       fifo_word;
    logic              fifo_valid;
    logic              fifo_ready;
    logic [15:0]       samples_left;
    logic [1:0]        lane;
    logic [47:0]       sample_acc;
    logic [1:0]        trl_ch;
    logic [1:0]        cnt_idx;
    logic [63:0]       byte_shift;
    logic [2:0]        byte_idx;
    logic              byte_busy;
    logic              stop_seen;
    logic [15:0]       wave_len;
    logic [43:0]       ev_time;
    logic              ev_ok;

    function automatic logic [15:0] lmef_wlen(input logic [1:0] sel);
        unique case (sel)
            2'h0:    lmef_wlen = LMEF_WLEN_4K;
            2'h1:    lmef_wlen = LMEF_WLEN_8K;
            2'h2:    lmef_wlen = LMEF_WLEN_16K;
            default: lmef_wlen = LMEF_WLEN_32K;
        endcase
    endfunction

    function automatic logic [63:0] lmef_pick(input logic [255:0] v, input logic [1:0] ch);
        lmef_pick = v[ch*LMEF_WORD_W +: LMEF_WORD_W];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Dig inputs come from pins, two flops first
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            dig_meta <= 8'h00;
            dig_sync <= 8'h00;
        end else begin
            dig_meta <= dig_in;
            dig_sync <= dig_meta;
        end
    end

    // Timestamp: 8 ns ticks alternate +2/+3, so 40 ns gives exactly 5; else 1 ms ticks
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            timestamp  <= 44'h000_0000_0000;
            coarse_div <= 26'h000_0000;
        end else if (fine_time_en) begin
            timestamp  <= timestamp + 44'(LMEF_FINE_STEP) + 44'(coarse_div[0]);
            coarse_div <= {25'h0, ~coarse_div[0]};
        end else if (coarse_div == 26'(LMEF_COARSE_CYC - 1)) begin
            timestamp  <= timestamp + 44'h1;
            coarse_div <= 26'h000_0000;
        end else begin
            coarse_div <= coarse_div + 26'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event word fields
    assign wave_len = lmef_wlen(wave_len_sel);
    always_comb begin
        ev_time = timestamp;
        if (pulse_width_en) begin
            ev_time[43:32] = ev_pulse_width;
        end
        if (tag_en) begin
            ev_time[43:36] = dig_sync;
        end
    end
    // Disabled channels and rejected pile-up are dropped silently
    assign ev_ok = channel_enable_mask[ev_channel]
                   && !(ev_pileup && sample_mode[LMEF_MODE_PUR_LSB + ev_channel]);

    always_comb begin
        frame_valid = 1'b0;
        frame_word  = 64'h0;
        ev_ready    = 1'b0;
        smp_ready   = 1'b0;
        unique case (state)
            LMEF_IDLE: begin
                // Held off once a stop is pending, so no header lacks its samples
                ev_ready = (frame_ready || !ev_ok) && !(stop_seen || acq_stop);
                if (ev_valid && ev_ok && !(stop_seen || acq_stop)) begin
                    frame_valid = 1'b1;
                    frame_word[LMEF_CH_LSB +: 2]    = ev_channel;
                    frame_word[LMEF_PILE_BIT]        = ev_pileup;
                    frame_word[LMEF_TS_LSB +: LMEF_TS_W] = ev_time;
                    if (sample_mode[LMEF_MODE_PHA_LSB + ev_channel]) begin
                        frame_word[LMEF_VAL_LSB +: 16] = ev_adc;
                    end else begin
                        frame_word[LMEF_WAVE_BIT]      = 1'b1;
                        frame_word[LMEF_VAL_LSB +: 16] = wave_len;
                    end
                end
            end
            LMEF_WAVE: begin
                smp_ready = (lane != 2'h3) || frame_ready;
                if (smp_valid && lane == 2'h3) begin
                    frame_valid = 1'b1;
                    frame_word  = {smp_data, sample_acc};
                end
            end
            LMEF_TRL_HD: begin
                frame_valid = 1'b1;
                frame_word[LMEF_CH_LSB +: 2]     = trl_ch;
                frame_word[LMEF_WAVE_BIT]         = 1'b1;
                frame_word[LMEF_VAL_LSB +: 16]    = LMEF_TRAILER_LEN;
            end
            LMEF_TRL_CNT: begin
                frame_valid = 1'b1;
                unique case (cnt_idx)
                    2'h0:    frame_word = lmef_pick(real_time, trl_ch);
                    2'h1:    frame_word = lmef_pick(live_time, trl_ch);
                    default: frame_word = lmef_pick(event_count, trl_ch);
                endcase
            end
            default: begin
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer; a stop during a waveform waits for its samples to finish
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            stop_seen <= 1'b0;
        end else if (acq_stop) begin
            stop_seen <= 1'b1;
        end else if (state == LMEF_DONE) begin
            stop_seen <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state        <= LMEF_IDLE;
            samples_left <= 16'h0;
            lane         <= 2'h0;
            sample_acc   <= 48'h0;
            trl_ch       <= 2'h0;
            cnt_idx      <= 2'h0;
            trailer_done <= 1'b0;
        end else begin
            trailer_done <= 1'b0;
            unique case (state)
                LMEF_IDLE: begin
                    if (stop_seen || acq_stop) begin
                        trl_ch <= 2'h0;
                        state  <= LMEF_DONE;
                        if (channel_enable_mask[0]) begin
                            state <= LMEF_TRL_HD;
                        end else begin
                            state <= LMEF_HEAD;
                        end
                    end else if (ev_valid && ev_ok && frame_ready
                                 && !sample_mode[LMEF_MODE_PHA_LSB + ev_channel]) begin
                        samples_left <= wave_len;
                        lane         <= 2'h0;
                        sample_acc   <= 48'h0;
                        state        <= LMEF_WAVE;
                    end
                end
                LMEF_WAVE: begin
                    if (smp_valid && smp_ready) begin
                        if (lane != 2'h3) begin
                            sample_acc[lane*16 +: 16] <= smp_data;
                        end else begin
                            sample_acc <= 48'h0;
                        end
                        lane         <= lane + 2'h1;
                        samples_left <= samples_left - 16'h1;
                        if (samples_left == 16'h0) begin
                            state <= LMEF_IDLE;
                        end
                    end
                end
                LMEF_HEAD: begin
                    // Skip to the next enabled channel
                    if (trl_ch == 2'h3) begin
                        state        <= LMEF_DONE;
                    end else begin
                        trl_ch <= trl_ch + 2'h1;
                        if (channel_enable_mask[trl_ch + 2'h1]) begin
                            state <= LMEF_TRL_HD;
                        end
                    end
                end
                LMEF_TRL_HD: begin
                    if (frame_ready) begin
                        cnt_idx <= 2'h0;
                        state   <= LMEF_TRL_CNT;
                    end
                end
                LMEF_TRL_CNT: begin
                    if (frame_ready) begin
                        cnt_idx <= cnt_idx + 2'h1;
                        if (cnt_idx == LMEF_NCNT) begin
                            state <= LMEF_HEAD;
                        end
                    end
                end
                LMEF_DONE: begin
                    trailer_done <= 1'b1;
                    state        <= LMEF_IDLE;
                end
                default: begin
                    state <= LMEF_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Buffering; a full FIFO stalls events and samples upstream
    lmef_fifo #(
        .WIDTH (LMEF_WORD_W),
        .DEPTH (LMEF_FIFO_DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .nrst      (nrst),
        .in_valid  (frame_valid),
        .in_ready  (frame_ready),
        .in_data   (frame_word),
        .out_valid (fifo_valid),
        .out_ready (fifo_ready),
        .out_data  (fifo_word)
    );

    // Byte serialiser, least significant byte first
    assign fifo_ready = !byte_busy;
    assign byte_valid = byte_busy;
    assign byte_data  = byte_shift[7:0];
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            byte_busy  <= 1'b0;
            byte_shift <= 64'h0;
            byte_idx   <= 3'h0;
        end else if (!byte_busy) begin
            if (fifo_valid) begin
                byte_shift <= fifo_word;
                byte_idx   <= 3'h0;
                byte_busy  <= 1'b1;
            end
        end else if (byte_ready) begin
            byte_shift <= {8'h00, byte_shift[63:8]};
            byte_idx   <= byte_idx + 3'h1;
            if (byte_idx == 3'h7) begin
                byte_busy <= 1'b0;
            end
        end
    end
endmodule // lmef_framer
`default_nettype wire

//--- sim/lmef_framer_props.sv
// Checker for the list-mode framer: byte stream and rebuilt word layout.
// Assumes it sees only the top module's ports, one clock domain.
`timescale 1ns/100ps
`default_nettype none
module lmef_framer_props (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        nrst,
    // Configuration
    input wire logic [3:0]  channel_enable_mask,
    input wire logic [7:0]  sample_mode,
    input wire logic        fine_time_en,
    // Byte stream and status
    input wire logic        byte_valid,
    input wire logic        byte_ready,
    input wire logic [7:0]  byte_data,
    input wire logic        trailer_done,
    input wire logic [43:0] timestamp
);
    logic [2:0]  bcnt;
    logic [55:0] acc;
    logic [63:0] w;
    logic        wv;
    logic        hdr;
    logic [13:0] skip;
    wire         take = byte_valid && byte_ready;
    wire  [63:0] full = {byte_data, acc};
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////////////////
    // Rebuild words; skip steps over sample and counter words
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            bcnt <= 3'h0;
            acc  <= '0;
            w    <= '0;
            wv   <= 1'b0;
            hdr  <= 1'b0;
            skip <= '0;
        end else begin
            wv <= take && bcnt == 3'h7;
            if (take) begin
                bcnt <= bcnt + 3'h1;
                if (bcnt != 3'h7) acc[8*bcnt +: 8] <= byte_data;
                else begin
                    w   <= full;
                    hdr <= skip == '0;
                    if (skip != '0) skip <= skip - 14'h1;
                    else if (full[3] && full[63:48] == 16'h000b) skip <= 14'h3;
                    else if (full[3]) skip <= 14'((17'(full[63:48]) + 17'h1) >> 2);
                end
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    a_byte_hold: assert property (byte_valid && !byte_ready |=> byte_valid && $stable(byte_data))
        else $error("byte changed while stalled");
    a_byte_run: assert property (bcnt != 3'h0 |-> byte_valid)
        else $error("byte valid dropped inside a word");
    a_word_gap: assert property (take && bcnt == 3'h7 |=> !byte_valid)
        else $error("no gap after eighth byte");
    a_trl_zero_ts: assert property (wv && hdr && w[3] && w[63:48] == 16'h000b |-> w[47:4] == 44'h0)
        else $error("trailer header time not zero");
    a_wave_len_ok: assert property (wv && hdr && w[3] |-> w[63:48] inside {16'h000b, 16'h0fff, 16'h1fff,
        16'h3fff, 16'h7fff})
        else $error("illegal waveform length");
    a_chan_on: assert property (wv && hdr |-> channel_enable_mask[w[1:0]])
        else $error("word from disabled channel");
    a_pile_drop: assert property (wv && hdr && !w[3] && w[2] |-> !sample_mode[4 + w[1:0]])
        else $error("piled event passed rejection");
    a_mode_match: assert property (wv && hdr |-> (w[63:48] == 16'h000b && w[3]) || (w[3] != sample_mode[w[1:0]]))
        else $error("word kind differs from channel mode");
    a_ts_fine: assert property (fine_time_en && $past(fine_time_en) && $past(fine_time_en, 2) |->
        timestamp == $past(timestamp, 2) + 44'h5)
        else $error("fine timestamp step wrong");
    a_done_pulse: assert property (trailer_done |=> !trailer_done)
        else $error("trailer done longer than a cycle");
endmodule // lmef_framer_props
bind lmef_framer lmef_framer_props i_props (.sys_clk(sys_clk), .nrst(nrst),
    .channel_enable_mask(channel_enable_mask), .sample_mode(sample_mode), .fine_time_en(fine_time_en),
    .byte_valid(byte_valid), .byte_ready(byte_ready), .byte_data(byte_data), .trailer_done(trailer_done),
    .timestamp(timestamp));
`default_nettype wire

//--- sim/lmef_host.sv
// Host model: takes the byte stream and rebuilds 64-bit list words.
// Assumes the bench drives hold off the rising edge.
`timescale 1ns/100ps
`default_nettype none
module lmef_host (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    // Stall request
    input  wire logic        hold,
    // Byte stream
    input  wire logic        byte_valid,
    output logic             byte_ready,
    input  wire logic [7:0]  byte_data,
    // Rebuilt words
    output logic             word_valid,
    output logic [63:0]      word,
    output logic             is_trl
);
    logic [2:0]  n;
    logic [55:0] part;
    assign byte_ready = !hold;
    assign is_trl = word[3] && word[63:48] == 16'h000b;
    ////////////////////////////////////////////////////////////////////////////
    // Least significant byte arrives first
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            n          <= 3'h0;
            part       <= '0;
            word       <= '0;
            word_valid <= 1'b0;
        end else begin
            word_valid <= byte_valid && byte_ready && n == 3'h7;
            if (byte_valid && byte_ready) begin
                n <= n + 3'h1;
                if (n == 3'h7) word <= {byte_data, part};
                else part[8*n +: 8] <= byte_data;
            end
        end
    end
endmodule // lmef_host
`default_nettype wire

//--- sim/lmef_framer_tb_top.sv
// Bench for the list-mode framer: events, waveform, fill and trailers.
// Assumes coarse time stays zero, as the run ends well inside 1 ms.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
module lmef_framer_tb_top;
    import lmef_pkg::*;
    logic sys_clk = 0, nrst = 0, fine_time_en = 0, tag_en = 0, pulse_width_en = 0, acq_stop = 0;
    logic ev_valid = 0, ev_pileup = 0, smp_valid = 0, stall = 1, hold = 1, ok;
    logic [3:0] channel_enable_mask = 4'hf;
    logic [7:0] sample_mode = 8'h0f, dig_in = 8'h00;
    logic [1:0] wave_len_sel = 2'h0, ev_channel = 2'h0;
    logic [15:0] ev_adc = 16'h0, smp_data = 16'h0;
    logic [11:0] ev_pulse_width = 12'h0;
    logic [255:0] real_time = '0, live_time = '0, event_count = '0;
    logic ev_ready, smp_ready, byte_valid, byte_ready, trailer_done, word_valid;
    logic [7:0] byte_data;
    logic [43:0] timestamp;
    logic [63:0] word, acc, exp_w;
    logic [63:0] q[$];
    logic [31:0] seed = 32'h45, r;
    int n_fail = 0, total_checks = 0, n, t;
    always #10 sys_clk = ~sys_clk;
    lmef_framer i_dut (.sys_clk(sys_clk), .nrst(nrst), .channel_enable_mask(channel_enable_mask),
        .sample_mode(sample_mode), .fine_time_en(fine_time_en), .tag_en(tag_en), .pulse_width_en(pulse_width_en),
        .wave_len_sel(wave_len_sel), .acq_stop(acq_stop), .dig_in(dig_in), .ev_valid(ev_valid), .ev_ready(ev_ready),
        .ev_channel(ev_channel), .ev_pileup(ev_pileup), .ev_adc(ev_adc), .ev_pulse_width(ev_pulse_width),
        .smp_valid(smp_valid), .smp_ready(smp_ready), .smp_data(smp_data), .real_time(real_time),
        .live_time(live_time), .event_count(event_count), .byte_valid(byte_valid), .byte_ready(byte_ready),
        .byte_data(byte_data), .trailer_done(trailer_done), .timestamp(timestamp));
    lmef_host i_host (.sys_clk(sys_clk), .nrst(nrst), .hold(hold), .byte_valid(byte_valid),
        .byte_ready(byte_ready), .byte_data(byte_data), .word_valid(word_valid), .word(word), .is_trl());
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Expected event word; tag bits win over the width's top byte
    function automatic logic [63:0] ev_word(logic [1:0] ch, logic p, logic [15:0] v, logic [11:0] pw, logic wv);
        logic [43:0] ts;
        ts = 44'h0;
        if (pulse_width_en) ts[43:32] = pw;
        if (tag_en) ts[43:36] = dig_in;
        return {v, ts, wv, p, ch};
    endfunction
    // Request stays up until taken; refused after 20 cycles
    task automatic send_ev(input logic [1:0] ch, input logic p, input logic [15:0] v, input logic [11:0] pw);
        ev_valid = 1;
        ev_channel = ch;
        ev_pileup = p;
        ev_adc = v;
        ev_pulse_width = pw;
        // Let ev_ready settle on the new channel before it is read
        #1;
        t = 0;
        while (!ev_ready && t < 20) begin @(negedge sys_clk); t++; end
        ok = ev_ready;
        if (ok) begin @(posedge sys_clk); @(negedge sys_clk); end
    endtask
    task automatic drain(input string nm);
        ev_valid = 0;
        t = 0;
        while (q.size() != 0 && t < 20000) begin @(negedge sys_clk); t++; end
        `CHK("queue empty", 1'b1, q.size() == 0)
        $display("test %s done", nm);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Host stalls about a quarter of the time
    always @(negedge sys_clk) hold <= stall || xs() % 4 == 0;
    always @(negedge sys_clk) begin
        if (word_valid === 1'b1) begin
            exp_w = (q.size() != 0) ? q.pop_front() : 64'hx;
            `CHK("word", exp_w, word)
        end
    end
    initial begin
        repeat (45000) @(posedge sys_clk);
        n_fail++;
        $display("ERROR watchdog expected finish seen timeout");
        test_done();
    end
    initial begin
        dig_in = 8'(xs());
        repeat (10) @(posedge sys_clk);
        @(negedge sys_clk);
        nrst = 1;
        stall = 0;
        // Dig inputs need two sync flops before a tagged event
        repeat (2) @(negedge sys_clk);
        // Mixed events, then a mask and pile-up rejection pass
        for (int c = 0; c < 2; c++) begin
            channel_enable_mask = c ? 4'h5 : 4'hf;
            sample_mode = c ? 8'h3f : 8'h0f;
            for (int i = 0; i < 24; i++) begin
                r = xs();
                {tag_en, pulse_width_en} = r[21:20];
                if (channel_enable_mask[r[1:0]] && !(r[2] && sample_mode[4 + r[1:0]]))
                    q.push_back(ev_word(r[1:0], r[2], r[31:16], r[15:4], 1'b0));
                send_ev(r[1:0], r[2], r[31:16], r[15:4]);
            end
            drain("events");
        end
        // Fill the buffer with the host stalled until events are refused
        stall = 1;
        channel_enable_mask = 4'hf;
        sample_mode = 8'h0f;
        n = 0;
        ok = 1;
        while (ok && n < 40) begin
            r = xs();
            send_ev(r[1:0], 1'b0, r[31:16], r[15:4]);
            if (ok) q.push_back(ev_word(r[1:0], 1'b0, r[31:16], r[15:4], 1'b0));
            if (ok) n++;
        end
        `CHK("fill count", 1'b1, n >= 32 && n < 40)
        stall = 0;
        drain("fill");
        // Waveform of 4096 samples on channel 0
        channel_enable_mask = 4'h1;
        sample_mode = 8'h0e;
        {tag_en, pulse_width_en} = 2'h0;
        q.push_back(ev_word(2'h0, 1'b0, LMEF_WLEN_4K, 12'h0, 1'b1));
        send_ev(2'h0, 1'b0, 16'h1234, 12'h0);
        ev_valid = 0;
        for (int i = 0; i < 4096; i++) begin
            smp_data = 16'(xs());
            smp_valid = 1;
            acc[16*(i%4) +: 16] = smp_data;
            if (i % 4 == 3) q.push_back(acc);
            t = 0;
            while (!smp_ready && t < 100) begin @(negedge sys_clk); t++; end
            `CHK("sample taken", 1'b1, smp_ready)
            @(posedge sys_clk);
            @(negedge sys_clk);
        end
        smp_valid = 0;
        drain("waveform");
        // Trailers for channels 0, 1 and 3
        channel_enable_mask = 4'hb;
        sample_mode = 8'h0f;
        for (int k = 0; k < 8; k++) {real_time[32*k +: 32], live_time[32*k +: 32], event_count[32*k +: 32]} = {xs(), xs(), xs()};
        for (int ch = 0; ch < 4; ch++) begin
            if (channel_enable_mask[ch]) begin
                q.push_back({LMEF_TRAILER_LEN, 44'h0, 2'b10, 2'(ch)});
                q.push_back(real_time[64*ch +: 64]);
                q.push_back(live_time[64*ch +: 64]);
                q.push_back(event_count[64*ch +: 64]);
            end
        end
        acq_stop = 1;
        @(negedge sys_clk);
        acq_stop = 0;
        t = 0;
        while (trailer_done !== 1'b1 && t < 500) begin @(negedge sys_clk); t++; end
        `CHK("trailer_done", 1'b1, trailer_done)
        drain("trailers");
        fine_time_en = 1;
        @(negedge sys_clk);
        acc = 64'(timestamp);
        repeat (20) @(negedge sys_clk);
        `CHK("timestamp", acc[43:0] + 44'(20 * LMEF_CLK_NS / LMEF_FINE_NS), timestamp)
        $display("test timestamp done");
        test_done();
    end
endmodule // lmef_framer_tb_top
`default_nettype wire
